// ### dv/sys_dma_model.sv
// System memory logic model that acknowledges a DMA done notification.
// Assumes the notify outputs of the config bank on the same clock.
`timescale 1ns/1ps

module sys_dma_model (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_notify_done,
    input wire logic [3:0] i_delay,
    output logic o_sys_dma_done
);
    logic [3:0] wait_reg; // Cycles left before acknowledging

    // Acknowledge one cycle after the programmed wait while done stands
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset || !i_notify_done)
        begin
            wait_reg <= i_delay;
            o_sys_dma_done <= 1'b0;
        end
        else
        begin
            wait_reg <= (wait_reg != 4'h0) ? wait_reg - 4'h1 : 4'h0;
            o_sys_dma_done <= (wait_reg == 4'h0) && !o_sys_dma_done;
        end
    end
endmodule

// ### dv/usb_otg_global_config_regs_bench.sv
// Self-checking bench of the global config bank and its DMA done handshake.
// Assumes the defines header and package are compiled before this file.
`timescale 1ns/1ps
`include "usb_otg_cfg_defs.svh"

module usb_otg_global_config_regs_bench;
    logic clk = 0, rst = 1, rd = 0, wr = 0, bvalid = 0, iddig = 1, mbig = 0, ext = 0;
    logic pend = 0, ph = 0, pe = 0, nh = 0, ne = 0, ded = 0, sdone, wreq, irq, xirq;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0, rdata, q, b, u;
    logic [3:0] dly = 4'h0, dburst;
    logic [2:0] mburst;
    logic srem, dbig, host, ted, ctx, pirq, nirq, eirq, hs, seen, got, eh, ce = 1;
    usb_otg_cfg_pkg::dma_write_evt_t evt = '0;
    usb_otg_cfg_pkg::dma_notify_t ntf;
    int n_errors = 0, comparisons = 0, i;

    // Free running system clock
    always #2 clk = ~clk;

    usb_otg_global_config_regs DUT (.i_sys_clk(clk), .i_reset(rst), .i_clk_en(ce),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_bvalid_pin(bvalid), .i_iddig_pin(iddig), .i_master_big_endian(mbig),
        .i_external_dma(ext), .i_dma_evt(evt), .i_sys_dma_done(sdone), .o_dma_notify(ntf),
        .o_transfer_complete_irq(xirq), .o_dma_burst(dburst), .o_master_burst(mburst),
        .o_single_remainder(srem), .i_ptx_half_empty(ph), .i_ptx_empty(pe),
        .i_nptx_half_empty(nh), .i_nptx_empty(ne), .i_dedicated_fifo(ded),
        .o_periodic_fifo_empty_irq(pirq), .o_nonperiodic_fifo_empty_irq(nirq),
        .o_in_endpoint_fifo_empty_irq(eirq), .i_core_irq_pending(pend), .o_irq(irq),
        .o_descriptor_big_endian(dbig), .o_host_mode(host),
        .o_transmit_end_delay_enable(ted), .o_corrupt_tx(ctx));

    sys_dma_model partner (.i_sys_clk(clk), .i_reset(rst), .i_notify_done(ntf.done),
        .i_delay(dly), .o_sys_dma_done(sdone));

    // Value compare
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error t=%0t got %h expected %h", $time, g, e);
        end
    endtask

    // One Avalon transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        // Launch just after an edge; one idle edge between calls
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        // Hold everything until waitrequest is sampled low at a rising edge
        while (wreq !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        chk(n < 20, 1);
        // Read data taken at the accepting edge, then release
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // One DMA write: start, done, then watch notification and completion
    task automatic dma(input logic lst);
        @(posedge clk);
        evt <= '{1'b1, 1'b0, lst, 5'h0B};
        @(posedge clk);
        evt.start <= 1'b0;
        @(negedge clk);
        chk(ntf.req, hs);
        if (hs)
            chk(ntf.chep, 5'h0B);
        @(posedge clk);
        evt.done <= 1'b1;
        @(posedge clk);
        evt.done <= 1'b0;
        seen = 0;
        got = 0;
        repeat (24)
        begin
            @(negedge clk);
            seen |= ntf.done;
            got |= xirq;
        end
        chk(seen, hs);
        chk(got, lst);
    endtask

    // Closing report
    task automatic end_of_test;
        $display("n_errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        void'($urandom(32'hB9B1));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        bus(0, `OFS_BUS_CFG, 0);
        chk(q, 0);
        bus(1, 6'h10, 32'hFFFFFFFF);
        bus(0, 6'h10, 0);
        chk(q, 0);
        for (i = 0; i < 12; i++)
        begin
            {mbig, ext, iddig, pend, ph, pe, nh, ne, ded} <= 9'($urandom);
            b = $urandom;
            u = $urandom & 32'h7FFFFFFF;
            bus(1, `OFS_BUS_CFG, b);
            bus(1, `OFS_USB_CFG, u);
            bus(0, `OFS_BUS_CFG, 0);
            chk(q, b & `BUS_CFG_WMASK);
            bus(0, `OFS_USB_CFG, 0);
            chk(q, u & `USB_CFG_WMASK);
            @(negedge clk);
            // Expected role: device force wins, then host force, then ID pin
            eh = u[30] ? 1'b0 : (u[29] | !iddig);
            chk(dbig, mbig ^ b[24]);
            chk(srem, b[5] & b[23]);
            chk(dburst, (b[5] & ext & !b[4]) ? b[4:1] : 4'h0);
            if (!ext)
                chk(mburst, (b[5] && b[1] && !b[4]) ? b[3:1] : 3'h0);
            chk(host, eh);
            chk(ted, u[28] & !eh);
            chk(ctx, 0);
            chk(irq, b[0] & pend);
            chk(pirq, eh & !b[5] & (b[8] ? pe : ph));
            chk(nirq, !b[5] & (eh | !ded) & (b[7] ? ne : nh));
            chk(eirq, !b[5] & !eh & ded & (b[7] ? ne : nh));
        end
        bus(1, `OFS_BUS_CFG, 32'h1);
        pend <= 1'b0;
        bvalid <= 1'b1;
        repeat (8) @(posedge clk);
        bvalid <= 1'b0;
        repeat (8) @(posedge clk);
        bus(0, `OFS_OTG_EVENT, 0);
        chk(q, 32'h4);
        chk(irq, 1);
        bus(1, `OFS_OTG_EVENT, 32'h4);
        bus(0, `OFS_OTG_EVENT, 0);
        chk(q, 0);
        // Clock enable low: a bvalid pulse must leave no trace
        ce <= 1'b0;
        bvalid <= 1'b1;
        repeat (8) @(posedge clk);
        bvalid <= 1'b0;
        repeat (8) @(posedge clk);
        ce <= 1'b1;
        bus(0, `OFS_OTG_EVENT, 0);
        chk(q, 0);
        for (i = 0; i < 8; i++)
        begin
            dly <= 4'($urandom_range(0, 5));
            bus(1, `OFS_BUS_CFG, 32'h20 | (32'(i[1]) << 21) | (32'(i[2]) << 22));
            hs = i[1] & (i[2] | i[0]);
            dma(i[0]);
        end
        end_of_test();
    end
endmodule

// ### hdl/dma_done_handshake.sv
// DMA write notification and system done handshake.
// Assumes events come from logic on the same clock.
`timescale 1ns/1ps

module dma_done_handshake (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic i_remote_memory_wait,
    input wire logic i_notify_every_write,
    input wire usb_otg_cfg_pkg::dma_write_evt_t i_evt,
    input wire logic i_sys_dma_done,
    output usb_otg_cfg_pkg::dma_notify_t o_notify,
    output logic o_transfer_complete_irq
);
    usb_otg_cfg_pkg::hs_state_t state_reg, state_next; // Handshake state
    usb_otg_cfg_pkg::dma_notify_t notify_reg, notify_next; // Registered outputs
    logic xfer_reg, xfer_next; // Completion pulse

    // Next state of the handshake
    always_comb
    begin
        state_next = state_reg;
        notify_next = notify_reg;
        xfer_next = 1'b0;
        unique case (state_reg)
            usb_otg_cfg_pkg::HS_IDLE:
                if (i_evt.start)
                begin
                    notify_next.last = i_evt.last;
                    notify_next.chep = i_evt.chep;
                    // Notify every write or only the last one
                    if (i_remote_memory_wait && (i_notify_every_write || i_evt.last))
                    begin
                        notify_next.req = 1'b1;
                        state_next = usb_otg_cfg_pkg::HS_WRITING;
                    end
                    else
                    begin
                        state_next = usb_otg_cfg_pkg::HS_LOCAL;
                    end
                end
            usb_otg_cfg_pkg::HS_LOCAL:
                // Complete at our own boundary, no system wait
                if (i_evt.done)
                begin
                    xfer_next = notify_reg.last;
                    state_next = usb_otg_cfg_pkg::HS_IDLE;
                end
            usb_otg_cfg_pkg::HS_WRITING:
                // Writes finished: flag done, await system
                if (i_evt.done)
                begin
                    notify_next.req = 1'b0;
                    notify_next.done = 1'b1;
                    state_next = usb_otg_cfg_pkg::HS_WAIT_SYS;
                end
            usb_otg_cfg_pkg::HS_WAIT_SYS:
                // System acknowledges the data landed
                if (i_sys_dma_done)
                begin
                    notify_next.done = 1'b0;
                    xfer_next = notify_reg.last;
                    state_next = usb_otg_cfg_pkg::HS_IDLE;
                end
        endcase
    end

    // Registers only
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            state_reg <= usb_otg_cfg_pkg::HS_IDLE;
            notify_reg <= '0;
            xfer_reg <= 1'b0;
        end
        else if (i_clk_en)
        begin
            state_reg <= state_next;
            notify_reg <= notify_next;
            xfer_reg <= xfer_next;
        end
    end

    assign o_notify = notify_reg;
    assign o_transfer_complete_irq = xfer_reg;

    // Checks
    property p_no_notify_local;
        @(posedge i_sys_clk) disable iff (i_reset)
        state_reg == usb_otg_cfg_pkg::HS_LOCAL |-> !o_notify.req && !o_notify.done;
    endproperty
    a_no_notify_local: assert property (p_no_notify_local)
        else $error("dma notify raised on a local write");

    property p_wait_sys;
        @(posedge i_sys_clk) disable iff (i_reset)
        o_notify.done && !i_sys_dma_done |=> !i_clk_en || o_notify.done;
    endproperty
    a_wait_sys: assert property (p_wait_sys)
        else $error("dma done dropped before system done");

    property p_req_when_notify;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_clk_en && state_reg == usb_otg_cfg_pkg::HS_IDLE && i_evt.start
            && i_remote_memory_wait && i_notify_every_write |=> o_notify.req;
    endproperty
    a_req_when_notify: assert property (p_req_when_notify)
        else $error("dma request missing with notify all");

    c_handshake: cover property (@(posedge i_sys_clk) disable iff (i_reset)
        o_notify.done ##[1:20] o_transfer_complete_irq);
endmodule

// ### hdl/usb_otg_cfg_defs.svh
// Offsets, field positions, reset values and codes of the global config bank.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef USB_OTG_CFG_DEFS_SVH
`define USB_OTG_CFG_DEFS_SVH

// Register byte offsets
`define AVS_ADDR_W 6
`define OFS_OTG_EVENT 6'h04
`define OFS_BUS_CFG 6'h08
`define OFS_USB_CFG 6'h0C

// Reset value and writable masks
`define REG_RESET 32'h00000000
`define BUS_CFG_WMASK 32'h01E001BF
`define USB_CFG_WMASK 32'h70000000

// Event status bits
`define BIT_SESSION_END 2

// Bus config bits
`define BIT_DESC_INVERT 24
`define BIT_SINGLE_REM 23
`define BIT_NOTIFY_ALL 22
`define BIT_REMOTE_WAIT 21
`define BIT_PTX_LEVEL 8
`define BIT_NPTX_LEVEL 7
`define BIT_DMA_MODE 5
`define BURST_HI 4
`define BURST_LO 1
`define BIT_IRQ_UNMASK 0

// USB config bits
`define BIT_CORRUPT_TX 31
`define BIT_FORCE_DEV 30
`define BIT_FORCE_HOST 29
`define BIT_TX_END_DELAY 28
`define BIT_INTERCHIP_CAP 26

// Burst select codes for internal DMA and the highest external DMA code
`define SEL_SINGLE 4'h0
`define SEL_INCR 4'h1
`define SEL_INCR4 4'h3
`define SEL_INCR8 4'h5
`define SEL_INCR16 4'h7
`define SEL_EXT_MAX 4'h7

// Master burst type encodings on the system bus
`define HB_SINGLE 3'h0
`define HB_INCR 3'h1
`define HB_INCR4 3'h3
`define HB_INCR8 3'h5
`define HB_INCR16 3'h7

// Synchroniser depth and channel number width
`define SYNC_DEPTH 3
`define CHEP_W 5

`endif

// ### hdl/usb_otg_cfg_pkg.sv
// Types shared by the global config bank and its DMA-done handshake.
// Assumes the defines header is compiled alongside.
`include "usb_otg_cfg_defs.svh"

package usb_otg_cfg_pkg;

    // One DMA write event from the core's DMA engine
    typedef struct packed {
        logic start;
        logic done;
        logic last;
        logic [`CHEP_W-1:0] chep;
    } dma_write_evt_t;

    // Notification outputs toward the system memory logic
    typedef struct packed {
        logic req;
        logic done;
        logic last;
        logic [`CHEP_W-1:0] chep;
    } dma_notify_t;

    // Handshake states
    typedef enum logic [1:0] {HS_IDLE, HS_LOCAL, HS_WRITING, HS_WAIT_SYS} hs_state_t;

endpackage

// ### hdl/usb_otg_global_config_regs.sv
// Global configuration bank of the on-the-go controller: event status,
// bus config and upper USB config over an Avalon-MM slave.
// Assumes the transceiver pins are asynchronous and all else is on i_sys_clk.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps

// Functional notes
// - Bvalid falling sets sticky session end, W1C
// - Invert bit flips descriptor endianness from master
// - DMA remainder uses SINGLE when bit set
// - Remote wait: request, done, await system done
// - No remote wait: no handshake, complete immediately
// - Notify all writes or only the last
// - Periodic empty irq: half or fully empty
// - Nonperiodic/IN endpoint empty irq level select
// - DMA enable picks slave or DMA mode
// - External DMA drives burst length code out
// - Internal DMA burst type decode; slave single
// - Global unmask gates irq output only
// - Force bit selects device role over ID
// - Force bit selects host role over ID
// - Transmit end delay enable in device mode
// - Inter-chip capable reads zero, ignores writes
// - Software clears event bits to clear irq
module usb_otg_global_config_regs (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic [`AVS_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_bvalid_pin,
    input wire logic i_iddig_pin,
    input wire logic i_master_big_endian,
    input wire logic i_external_dma,
    input wire usb_otg_cfg_pkg::dma_write_evt_t i_dma_evt,
    input wire logic i_sys_dma_done,
    output usb_otg_cfg_pkg::dma_notify_t o_dma_notify,
    output logic o_transfer_complete_irq,
    output logic [3:0] o_dma_burst,
    output logic [2:0] o_master_burst,
    output logic o_single_remainder,
    input wire logic i_ptx_half_empty,
    input wire logic i_ptx_empty,
    input wire logic i_nptx_half_empty,
    input wire logic i_nptx_empty,
    input wire logic i_dedicated_fifo,
    output logic o_periodic_fifo_empty_irq,
    output logic o_nonperiodic_fifo_empty_irq,
    output logic o_in_endpoint_fifo_empty_irq,
    input wire logic i_core_irq_pending,
    output logic o_irq,
    output logic o_descriptor_big_endian,
    output logic o_host_mode,
    output logic o_transmit_end_delay_enable,
    output logic o_corrupt_tx
);
    // Register file
    logic [31:0] bus_config_reg, bus_config_next; // Bus config
    logic [31:0] usb_phy_config_reg, usb_phy_config_next; // USB config
    logic [31:0] otg_event_status_reg, otg_event_status_next; // Sticky events
    logic corrupt_tx_reg, corrupt_tx_next; // Write-only debug bit
    // Bus slave state
    logic ack_reg, ack_next; // Answer cycle marker
    logic [31:0] readdata_reg, readdata_next; // Read data
    // Pin synchronisers, one chain per pin
    logic [`SYNC_DEPTH-1:0] sync_reg [2];
    logic [1:0] pin_stable_reg; // Filtered pin levels
    logic bvalid_prev_reg; // For falling-edge detect
    // Decoded controls
    logic [31:0] byte_mask; // Byte enables spread to bits
    logic wr_take; // Write takes effect this edge
    logic session_end_evt; // Bvalid fell
    logic dma_mode; // DMA mode selected
    logic [3:0] burst_sel; // Burst field
    logic force_dev; // Forced device role
    logic force_host; // Forced host role

    // Byte enables to a bit mask
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_byte
            assign byte_mask[8*g +: 8] = {8{i_avs_byteenable[g]}};
        end
    endgenerate

    // Three-stage synchroniser; level changes once stages two and three agree
    generate
        for (g = 0; g < 2; g++)
        begin : g_sync
            always_ff @(posedge i_sys_clk)
            begin
                if (i_reset)
                begin
                    sync_reg[g] <= '0;
                    pin_stable_reg[g] <= 1'b0;
                end
                else if (i_clk_en)
                begin
                    sync_reg[g] <= {sync_reg[g][`SYNC_DEPTH-2:0],
                        (g == 0) ? i_bvalid_pin : i_iddig_pin};
                    if (sync_reg[g][1] == sync_reg[g][2])
                    begin
                        pin_stable_reg[g] <= sync_reg[g][2];
                    end
                end
            end
        end
    endgenerate

    // Previous bvalid level
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
            bvalid_prev_reg <= 1'b0;
        else if (i_clk_en)
            bvalid_prev_reg <= pin_stable_reg[0];
    end

    assign session_end_evt = bvalid_prev_reg && !pin_stable_reg[0];
    assign wr_take = i_avs_write && ack_reg;

    // Bus slave: one wait cycle, then answer
    always_comb
    begin
        ack_next = (i_avs_read || i_avs_write) && !ack_reg;
        readdata_next = readdata_reg;
        if (i_avs_read && !ack_reg)
        begin
            // Reserved and unmapped bits read zero
            unique case (i_avs_address)
                `OFS_OTG_EVENT:
                    readdata_next = otg_event_status_reg;
                `OFS_BUS_CFG:
                    readdata_next = bus_config_reg & `BUS_CFG_WMASK;
                `OFS_USB_CFG:
                    readdata_next = usb_phy_config_reg & `USB_CFG_WMASK;
                default:
                    readdata_next = `REG_RESET;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            ack_reg <= 1'b0;
            readdata_reg <= `REG_RESET;
        end
        else if (i_clk_en)
        begin
            ack_reg <= ack_next;
            readdata_reg <= readdata_next;
        end
    end

    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
    assign o_avs_readdata = readdata_reg;

    // Register writes and event capture
    always_comb
    begin
        bus_config_next = bus_config_reg;
        usb_phy_config_next = usb_phy_config_reg;
        otg_event_status_next = otg_event_status_reg;
        corrupt_tx_next = corrupt_tx_reg;
        if (wr_take)
        begin
            unique case (i_avs_address)
                `OFS_BUS_CFG:
                    // Only documented fields take writes
                    bus_config_next = (bus_config_reg & ~(`BUS_CFG_WMASK & byte_mask))
                        | (i_avs_writedata & `BUS_CFG_WMASK & byte_mask);
                `OFS_USB_CFG:
                begin
                    // Inter-chip capable is not writable
                    usb_phy_config_next = (usb_phy_config_reg & ~(`USB_CFG_WMASK & byte_mask))
                        | (i_avs_writedata & `USB_CFG_WMASK & byte_mask);
                    if (i_avs_byteenable[3])
                        corrupt_tx_next = i_avs_writedata[`BIT_CORRUPT_TX];
                end
                `OFS_OTG_EVENT:
                    // Write one clears
                    if (i_avs_byteenable[0] && i_avs_writedata[`BIT_SESSION_END])
                        otg_event_status_next[`BIT_SESSION_END] = 1'b0;
                default:
                    otg_event_status_next = otg_event_status_reg;
            endcase
        end
        // Set wins over a clear in the same cycle
        if (session_end_evt)
            otg_event_status_next[`BIT_SESSION_END] = 1'b1;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            bus_config_reg <= `REG_RESET;
            usb_phy_config_reg <= `REG_RESET;
            otg_event_status_reg <= `REG_RESET;
            corrupt_tx_reg <= 1'b0;
        end
        else if (i_clk_en)
        begin
            bus_config_reg <= bus_config_next;
            usb_phy_config_reg <= usb_phy_config_next;
            otg_event_status_reg <= otg_event_status_next;
            corrupt_tx_reg <= corrupt_tx_next;
        end
    end

    // Field decode
    assign dma_mode = bus_config_reg[`BIT_DMA_MODE];
    assign burst_sel = bus_config_reg[`BURST_HI:`BURST_LO];
    assign force_dev = usb_phy_config_reg[`BIT_FORCE_DEV];
    assign force_host = usb_phy_config_reg[`BIT_FORCE_HOST];

    // Descriptor endianness
    assign o_descriptor_big_endian = i_master_big_endian
        ^ bus_config_reg[`BIT_DESC_INVERT];

    // Remainder as singles only in DMA mode
    assign o_single_remainder = dma_mode && bus_config_reg[`BIT_SINGLE_REM];

    // External DMA burst length, reserved codes and other modes drive zero
    assign o_dma_burst = (dma_mode && i_external_dma && burst_sel <= `SEL_EXT_MAX)
        ? burst_sel : `SEL_SINGLE;

    // Internal DMA burst type; slave mode and reserved codes use single
    always_comb
    begin
        o_master_burst = `HB_SINGLE;
        if (dma_mode && !i_external_dma)
        begin
            unique case (burst_sel)
                `SEL_INCR: o_master_burst = `HB_INCR;
                `SEL_INCR4: o_master_burst = `HB_INCR4;
                `SEL_INCR8: o_master_burst = `HB_INCR8;
                `SEL_INCR16: o_master_burst = `HB_INCR16;
                default: o_master_burst = `HB_SINGLE;
            endcase
        end
    end

    // Role: device force wins if both set, else ID pin low means host
    assign o_host_mode = force_dev ? 1'b0 : (force_host || !pin_stable_reg[1]);

    // Transmit end delay only in device role
    assign o_transmit_end_delay_enable = usb_phy_config_reg[`BIT_TX_END_DELAY]
        && !o_host_mode;
    assign o_corrupt_tx = corrupt_tx_reg;

    // FIFO empty interrupts, slave mode only
    assign o_periodic_fifo_empty_irq = !dma_mode && o_host_mode
        && (bus_config_reg[`BIT_PTX_LEVEL] ? i_ptx_empty : i_ptx_half_empty);
    assign o_nonperiodic_fifo_empty_irq = !dma_mode && !(i_dedicated_fifo && !o_host_mode)
        && (bus_config_reg[`BIT_NPTX_LEVEL] ? i_nptx_empty : i_nptx_half_empty);
    assign o_in_endpoint_fifo_empty_irq = !dma_mode && i_dedicated_fifo && !o_host_mode
        && (bus_config_reg[`BIT_NPTX_LEVEL] ? i_nptx_empty : i_nptx_half_empty);

    // Global gate on the interrupt line; status keeps updating
    assign o_irq = bus_config_reg[`BIT_IRQ_UNMASK]
        && (i_core_irq_pending || |otg_event_status_reg);

    // DMA write notification
    dma_done_handshake u_dma_done_handshake (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_clk_en(i_clk_en),
        .i_remote_memory_wait(dma_mode && bus_config_reg[`BIT_REMOTE_WAIT]),
        .i_notify_every_write(bus_config_reg[`BIT_NOTIFY_ALL]),
        .i_evt(i_dma_evt),
        .i_sys_dma_done(i_sys_dma_done),
        .o_notify(o_dma_notify),
        .o_transfer_complete_irq(o_transfer_complete_irq)
    );

    // Checks
    property p_session_set;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_clk_en && session_end_evt |=> otg_event_status_reg[`BIT_SESSION_END];
    endproperty
    a_session_set: assert property (p_session_set)
        else $error("session end flag not set on bvalid fall");

    property p_session_sticky;
        @(posedge i_sys_clk) disable iff (i_reset)
        otg_event_status_reg[`BIT_SESSION_END] && !wr_take |=>
            otg_event_status_reg[`BIT_SESSION_END];
    endproperty
    a_session_sticky: assert property (p_session_sticky)
        else $error("session end flag lost without a clear");

    property p_irq_masked;
        @(posedge i_sys_clk) disable iff (i_reset)
        !bus_config_reg[`BIT_IRQ_UNMASK] |-> !o_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt passed while masked");

    property p_slave_single;
        @(posedge i_sys_clk) disable iff (i_reset)
        !dma_mode |-> o_master_burst == `HB_SINGLE && !o_single_remainder;
    endproperty
    a_slave_single: assert property (p_slave_single)
        else $error("burst used in slave mode");

    property p_force_dev;
        @(posedge i_sys_clk) disable iff (i_reset)
        wr_take && i_avs_address == `OFS_USB_CFG && i_avs_byteenable[3] && i_clk_en
            && i_avs_writedata[`BIT_FORCE_DEV] |=> !o_host_mode;
    endproperty
    a_force_dev: assert property (p_force_dev)
        else $error("forced device role not taken");

    property p_cap_zero;
        @(posedge i_sys_clk) disable iff (i_reset)
        ack_reg && i_avs_read && i_avs_address == `OFS_USB_CFG
            |-> !o_avs_readdata[`BIT_INTERCHIP_CAP] && !o_avs_readdata[`BIT_CORRUPT_TX];
    endproperty
    a_cap_zero: assert property (p_cap_zero)
        else $error("inter-chip capable or debug bit read as one");

    property p_wait_once;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_clk_en && (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_wait_once: assert property (p_wait_once)
        else $error("slave waited more than one cycle");

    c_session: cover property (@(posedge i_sys_clk) disable iff (i_reset)
        session_end_evt ##[1:30] wr_take);
    c_irq: cover property (@(posedge i_sys_clk) disable iff (i_reset) o_irq);
    c_burst16: cover property (@(posedge i_sys_clk) disable iff (i_reset)
        o_master_burst == `HB_INCR16);
endmodule
